// ---- test/dmac_mem_model.sv ----
// memory model: on-chip ram and external memory behind one select
`timescale 1ns/1ps
module dmac_mem_model (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 srst,
	// internal ram port
	input  wire dmac_pkg::dmac_ibus_t intBus,
	output logic [31:0]               intRdata,
	output logic                      intAck,
	input  wire logic                 slow,
	// external memory pins
	input  wire dmac_pkg::dmac_ebus_t extBus,
	output logic [31:0]               extDataIn
);
	import dmac_pkg::*;
	logic [31:0] mem [0:255];
	logic [31:0] lastExt;
	logic [1:0]  waitCnt;
	// small window: 128 word entries internal, 128 word entries external
	function automatic logic [7:0] ix(input logic [31:0] a);
		return {a[31], a[6:0]};
	endfunction : ix
	// released pins show the inverse of the last value, never stale data
	assign extDataIn = (!extBus.chipSelectN && !extBus.rdN) ?
		mem[ix(extBus.addr)] : ~lastExt;
	// ram answers at once or after two idle cycles
	always @(posedge sys_clk) begin
		lastExt <= extDataIn;
		if (!extBus.chipSelectN && !extBus.weN)
			mem[ix(extBus.addr)] <= extBus.dout;
		if (srst) begin
			intAck  <= 1'b0;
			waitCnt <= 2'h0;
		end else if (intBus.req && !intAck &&
			waitCnt == (slow ? 2'h2 : 2'h0)) begin
			intAck   <= 1'b1;
			waitCnt  <= 2'h0;
			intRdata <= mem[ix(intBus.addr)];
			if (intBus.we)
				mem[ix(intBus.addr)] <= intBus.wdata;
		end else begin
			intAck   <= 1'b0;
			waitCnt  <= (intBus.req && !intAck) ? waitCnt + 2'h1 : 2'h0;
			intRdata <= ~intRdata;
		end
	end
endmodule : dmac_mem_model

// ---- test/tb_top.sv ----
// self-checking bench for the dual address dma channel
`timescale 1ns/1ps
module tb_top;
	import dmac_pkg::*;
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic        slow = 1'b0;
	dmac_avs_t   avsReq = '0;
	logic [31:0] avsReaddata, rd, intRdata, extDataIn;
	logic        avsWaitrequest, busOwn, transferEndIrq, intAck;
	dmac_ibus_t  intBus;
	dmac_ebus_t  extBus;
	int          fail_count = 0;
	int          n_compared = 0;
	int          cycles = 0;
	logic [31:0] exp[$];
	always #2 sys_clk = ~sys_clk;
	dmac_channel dmac_channel_i (.sys_clk(sys_clk), .srst(srst),
		.avsReq(avsReq), .avsReaddata(avsReaddata),
		.avsWaitrequest(avsWaitrequest), .intBus(intBus),
		.intRdata(intRdata), .intAck(intAck), .extBus(extBus),
		.extDataIn(extDataIn), .busOwn(busOwn),
		.transferEndIrq(transferEndIrq));
	dmac_mem_model dmac_mem_model_i (.sys_clk(sys_clk), .srst(srst),
		.intBus(intBus), .intRdata(intRdata), .intAck(intAck),
		.slow(slow), .extBus(extBus), .extDataIn(extDataIn));
	task report_and_stop;
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// watchdog, far above the longest expected run
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail_count++;
			report_and_stop();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] want);
		n_compared++;
		if (got !== want) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : chk
	// one avalon access, held until waitrequest is seen low
	task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avsReq <= '{read: !w, write: w, address: a, writedata: d,
			byteenable: 4'hf};
		do @(posedge sys_clk); while (avsWaitrequest !== 1'b0);
		rd = avsReaddata;
		avsReq.read  <= 1'b0;
		avsReq.write <= 1'b0;
	endtask : bus
	task run(input logic [31:0] s, input logic [31:0] d,
		input logic [1:0] ts, input logic tb, input logic ie, input int n);
		int          st;
		logic [15:0] c;
		st = (ts == TS_BYTE) ? 1 : (ts == TS_WORD) ? 2 : 4;
		c = {AM_INC, AM_INC, RS_AUTO, 2'h0, tb, ts, ie, 2'h0};
		exp.delete();
		for (int k = 0; k < n; k++) begin
			exp.push_back($urandom);
			dmac_mem_model_i.mem[{s[31], 7'(s + k * st)}] = exp[k];
		end
		bus(1'b1, OFS_SRC, s);
		bus(1'b1, OFS_DST, d);
		bus(1'b1, OFS_CNT, 32'(n));
		bus(1'b1, OFS_CTL, {16'h0, c});
		bus(1'b1, OFS_CTL, {16'h0, c | 16'h1});
		do bus(1'b0, OFS_CTL, 32'h0); while (rd[CTL_TE] !== 1'b1);
		chk({31'h0, transferEndIrq}, {31'h0, ie});
		chk({31'h0, busOwn}, 32'h0);
		bus(1'b0, OFS_CNT, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, OFS_SRC, 32'h0);
		chk(rd, s + 32'(n * st));
		bus(1'b0, OFS_DST, 32'h0);
		chk(rd, d + 32'(n * st));
		for (int k = 0; k < n; k++)
			chk(dmac_mem_model_i.mem[{d[31], 7'(d + k * st)}], exp[k]);
		bus(1'b1, OFS_CTL, {16'h0, c});
		bus(1'b0, OFS_CTL, 32'h0);
		chk(rd, {16'h0, c});
		chk({31'h0, transferEndIrq}, 32'h0);
	endtask : run
	initial begin
		void'($urandom(10449));
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		bus(1'b0, OFS_CTL, 32'h0);
		chk(rd, {16'h0, CTL_RST});
		bus(1'b1, 10'h100, 32'hffff_ffff);
		bus(1'b0, 10'h100, 32'h0);
		chk(rd, 32'h0);
		// no start while the global enable or auto source is missing
		bus(1'b1, OFS_CNT, 32'h2);
		bus(1'b1, OFS_CTL, {16'h0, AM_INC, AM_INC, RS_AUTO, 8'h11});
		repeat (20) @(posedge sys_clk);
		bus(1'b0, OFS_CNT, 32'h0);
		chk(rd, 32'h2);
		bus(1'b1, OFS_CTL, 32'h0000_5011);
		bus(1'b1, OFS_OPR, 32'h1);
		repeat (20) @(posedge sys_clk);
		bus(1'b0, OFS_CNT, 32'h0);
		chk(rd, 32'h2);
		bus(1'b1, OFS_CTL, 32'h0);
		run(32'hfff0_0000, 32'h0c00_0040, TS_LONG, 1'b1, 1'b1, 5);
		for (int i = 0; i < 8; i++) begin
			slow <= 1'($urandom);
			run(i[0] ? 32'h0c00_0000 : 32'hfff0_0000,
				(i[1] ? 32'h0c00_0000 : 32'hfff0_0000) + 32'h40,
				2'($urandom), i[2], 1'($urandom), $urandom_range(5, 1));
		end
		report_and_stop();
	end
endmodule : tb_top

// ---- verilog/dmac_channel.sv ----
// dual address dma channel with avalon register slave
// Overview of operation
// - both sides selected by address, internal side ends on acknowledge, external on timer
// - source and destination internal or external
// - each unit is read cycle then write
// - read data held, driven during write
// - auto request starts without request lines
// - increment adds data size to addresses
// - longword size moves 32 bits per unit
// - count register counts units, not bytes
// - enable bit written last starts channel
// - internal source read on internal bus first
// - external write drives select, strobe, address, data
// - pairs repeat until count reaches zero
// - end interrupt raised when enabled
// - auto request encoded as 0100
// - longword size encoded as 10
// - global enable gates all transfers
// - end flag set by hardware, zero clears
`timescale 1ns/1ps
module dmac_channel #(
	parameter int EXT_CYC = dmac_pkg::EXT_CYC_DEF
) (
	// clock and reset
	input  wire  logic                  sys_clk,
	input  wire  logic                  srst,
	// register slave
	input  wire  dmac_pkg::dmac_avs_t   avsReq,
	output logic [31:0]                 avsReaddata,
	output logic                        avsWaitrequest,
	// internal memory bus
	output dmac_pkg::dmac_ibus_t        intBus,
	input  wire  logic [31:0]           intRdata,
	input  wire  logic                  intAck,
	// external memory pins
	output dmac_pkg::dmac_ebus_t        extBus,
	input  wire  logic [31:0]           extDataIn,
	// status
	output logic                        busOwn,
	output logic                        transferEndIrq
);
	import dmac_pkg::*;

	// strobe timer is four bits wide, zero would wrap and expire only after 16 cycles
	if (EXT_CYC < 1 || EXT_CYC > 15) begin : g_bad_ext_cyc
		$error("EXT_CYC must lie in 1..15");
	end

	dmac_regs_t s;
	dmac_regs_t next_s;
	logic [31:0] delta;
	logic        go;
	logic        swWr;
	logic        accDone;
	logic        pairDone;
	logic [31:0] launchAddr;
	// lane-merged images of count and control
	logic [31:0] cntMerged;
	logic [31:0] ctlMerged;

	// merge written bytes into an old word
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		end
		return r;
	endfunction : be_merge

	// register images with written lanes merged in
	assign cntMerged = be_merge({{(32-CNT_W){1'b0}}, s.cnt},
		avsReq.writedata, avsReq.byteenable);
	assign ctlMerged = be_merge({16'h0000, s.ctl}, avsReq.writedata,
		avsReq.byteenable);

	// unit size in bytes
	always_comb begin
		case (s.ctl[CTL_TS +: 2])
			TS_BYTE: delta = 32'h0000_0001;
			TS_WORD: delta = 32'h0000_0002;
			TS_LONG: delta = 32'h0000_0004;
			default: delta = 32'h0000_0004;
		endcase
	end

	// start condition; software alone asks, no pin does
	assign go = s.ctl[CTL_DE] && s.global_channel_enable && !s.ctl[CTL_TE]
		&& (s.ctl[CTL_RS +: 4] == RS_AUTO)
		&& (s.cnt != '0);
	assign swWr = avsReq.write && !s.avsWait;
	// internal ack or external strobe timer expiry
	assign accDone = s.onExt ? (s.tmr == 4'h1) : intAck;
	assign pairDone = (s.st == ST_WR) && accDone;
	assign launchAddr = (s.st == ST_RDGO) ? s.src : s.dst;

	always_comb begin
		next_s = s;
		// pin data passes two flops first
		next_s.sync1 = extDataIn;
		next_s.sync2 = s.sync1;

		// one wait state, then the answer
		next_s.avsWait = 1'b1;
		if ((avsReq.read || avsReq.write) && s.avsWait) begin
			next_s.avsWait = 1'b0;
			case (avsReq.address)
				OFS_SRC: next_s.rdata = s.src;
				OFS_DST: next_s.rdata = s.dst;
				OFS_CNT: next_s.rdata = {{(32-CNT_W){1'b0}}, s.cnt};
				OFS_CTL: next_s.rdata = {16'h0000, s.ctl};
				OFS_OPR: next_s.rdata = {31'h0, s.global_channel_enable};
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end

		// software writes land before engine updates so hardware wins
		if (swWr) begin
			case (avsReq.address)
				OFS_SRC: next_s.src = be_merge(s.src, avsReq.writedata,
					avsReq.byteenable);
				OFS_DST: next_s.dst = be_merge(s.dst, avsReq.writedata,
					avsReq.byteenable);
				OFS_CNT: next_s.cnt = cntMerged[CNT_W-1:0];
				OFS_CTL: begin
					next_s.ctl = ctlMerged[15:0];
					// end flag only clears by zero, never set by software
					next_s.ctl[CTL_TE] = s.ctl[CTL_TE]
						&& next_s.ctl[CTL_TE];
				end
				OFS_OPR: begin
					if (avsReq.byteenable[0])
						next_s.global_channel_enable = avsReq.writedata[OPR_DME];
				end
				default: ;
			endcase
		end

		// transfer engine
		case (s.st)
			ST_IDLE: begin
				next_s.busOwn = 1'b0;
				if (go) begin
					next_s.st = ST_RDGO;
					next_s.busOwn = 1'b1;
				end
			end
			// read and write launch share one path, picked by address
			ST_RDGO, ST_WRGO: begin
				next_s.st = (s.st == ST_RDGO) ? ST_RD : ST_WR;
				next_s.onExt = ((launchAddr & INT_MASK) != INT_BASE);
				if ((launchAddr & INT_MASK) == INT_BASE) begin
					next_s.ibus.req = 1'b1;
					next_s.ibus.addr = launchAddr;
					next_s.ibus.we = (s.st == ST_WRGO);
					next_s.ibus.wdata = s.hold;
				end else begin
					next_s.ebus.chipSelectN = 1'b0;
					next_s.ebus.addr = launchAddr;
					next_s.ebus.rdN = (s.st == ST_WRGO);
					next_s.ebus.weN = (s.st == ST_RDGO);
					next_s.ebus.dout = s.hold;
					next_s.ebus.doe = (s.st == ST_WRGO);
					next_s.tmr = 4'(EXT_CYC);
				end
			end
			ST_RD: begin
				next_s.tmr = s.tmr - 4'h1;
				if (accDone) begin
					next_s.hold = s.onExt ? s.sync2 : intRdata;
					next_s.st = ST_WRGO;
				end
			end
			ST_WR: begin
				next_s.tmr = s.tmr - 4'h1;
				if (accDone) begin
					// step each address up or down by the unit size per its mode, or hold it
					case (s.ctl[CTL_SM +: 2])
						AM_INC: next_s.src = s.src + delta;
						AM_DEC: next_s.src = s.src - delta;
						default: next_s.src = s.src;
					endcase
					case (s.ctl[CTL_DM +: 2])
						AM_INC: next_s.dst = s.dst + delta;
						AM_DEC: next_s.dst = s.dst - delta;
						default: next_s.dst = s.dst;
					endcase
					next_s.cnt = s.cnt - 1'b1;
					if (s.cnt == {{(CNT_W-1){1'b0}}, 1'b1}) begin
						next_s.ctl[CTL_TE] = 1'b1;
						next_s.st = ST_IDLE;
						next_s.busOwn = 1'b0;
					end else if (s.ctl[CTL_TB] && s.ctl[CTL_DE] && s.global_channel_enable) begin
						next_s.st = ST_RDGO;
					end else begin
						// cycle steal: give the bus back between pairs
						next_s.st = ST_IDLE;
						next_s.busOwn = 1'b0;
					end
				end
			end
			default: next_s.st = ST_IDLE;
		endcase

		// strobes end when the access completes
		if ((s.st == ST_RD || s.st == ST_WR) && accDone) begin
			next_s.ibus.req = 1'b0;
			next_s.ibus.we = 1'b0;
			next_s.ebus.chipSelectN = 1'b1;
			next_s.ebus.rdN = 1'b1;
			next_s.ebus.weN = 1'b1;
			next_s.ebus.doe = 1'b0;
		end

		// interrupt follows flag while enabled
		next_s.irq = next_s.ctl[CTL_TE] && next_s.ctl[CTL_IE];

		if (srst) begin
			next_s = '0;
			next_s.ctl = CTL_RST;
			next_s.avsWait = 1'b1;
			next_s.ebus.chipSelectN = 1'b1;
			next_s.ebus.rdN = 1'b1;
			next_s.ebus.weN = 1'b1;
		end
	end

	// single state register
	always_ff @(posedge sys_clk) begin
		s <= next_s;
	end

	assign avsReaddata    = s.rdata;
	assign avsWaitrequest = s.avsWait;
	assign intBus         = s.ibus;
	assign extBus         = s.ebus;
	assign busOwn         = s.busOwn;
	assign transferEndIrq = s.irq;

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_start_gated: assert property (
		$rose(s.busOwn) |-> $past(s.global_channel_enable) && $past(s.ctl[CTL_DE]))
		else $error("channel started without both enables");
	a_auto_only: assert property (
		$rose(s.busOwn) |-> $past(s.ctl[CTL_RS +: 4]) == RS_AUTO)
		else $error("channel started without auto request");
	a_write_after_read: assert property (
		s.st == ST_WRGO |-> $past(s.st) == ST_RD)
		else $error("write launched without preceding read");
	a_hold_driven: assert property (
		(s.st == ST_WR && s.onExt) |-> s.ebus.dout == s.hold && s.ebus.doe)
		else $error("held data not on external bus");
	a_ext_strobe: assert property (
		$fell(s.ebus.weN) |-> (!s.ebus.weN && !s.ebus.chipSelectN)[*3])
		else $error("external write strobe too short");
	a_count_step: assert property (
		(pairDone && !swWr) |=> s.cnt == $past(s.cnt) - 1'b1)
		else $error("count did not step by one");
	a_end_flag: assert property (
		(pairDone && s.cnt == 1) |=> s.ctl[CTL_TE] && s.st == ST_IDLE)
		else $error("end flag missing after last unit");
	a_src_step: assert property (
		(pairDone && !swWr && s.ctl[CTL_SM +: 2] == AM_INC)
		|=> s.src == $past(s.src) + $past(delta))
		else $error("source address not advanced");
	a_burst_keep: assert property (
		(pairDone && s.cnt > 1 && s.ctl[CTL_TB] && s.ctl[CTL_DE] && s.global_channel_enable)
		|=> s.busOwn && s.st == ST_RDGO)
		else $error("bus released inside burst");
	a_irq_end: assert property (
		(pairDone && !swWr && s.cnt == 1 && s.ctl[CTL_IE]) |=> s.irq)
		else $error("end interrupt not raised");
	// one wait state, then waitrequest rises again
	a_wait_single: assert property (
		!s.avsWait |=> s.avsWait)
		else $error("waitrequest low for more than one cycle");

	// every access selects its side by address
	a_dual_select: assert property (
		(s.st == ST_RD || s.st == ST_WR)
		|-> (s.onExt ? !s.ebus.chipSelectN : s.ibus.req))
		else $error("access without an address select");
	a_int_src_first: assert property (
		(s.st == ST_RD && !s.onExt)
		|-> s.ibus.req && !s.ibus.we && s.ibus.addr == s.src
			&& s.ebus.chipSelectN)
		else $error("internal read not alone on its bus");
	a_ext_write_pins: assert property (
		(s.st == ST_WR && s.onExt)
		|-> !s.ebus.chipSelectN && !s.ebus.weN && s.ebus.addr == s.dst)
		else $error("external write pins not driven");
	a_int_hold: assert property (
		(s.st == ST_WR && !s.onExt) |-> s.ibus.we && s.ibus.wdata == s.hold)
		else $error("held data not on internal bus");
	a_read_no_write: assert property (
		s.st == ST_RD |-> s.ebus.weN && !s.ibus.we)
		else $error("write strobe active in read cycle");
	a_ext_read_len: assert property (
		$fell(s.ebus.rdN) |-> (!s.ebus.rdN && !s.ebus.chipSelectN)[*3])
		else $error("external read strobe too short");

	// address, count and flag bookkeeping
	a_dst_step: assert property (
		(pairDone && !swWr && s.ctl[CTL_DM +: 2] == AM_INC)
		|=> s.dst == $past(s.dst) + $past(delta))
		else $error("destination address not advanced");
	a_long_unit: assert property (
		(pairDone && !swWr && s.ctl[CTL_TS +: 2] == TS_LONG
			&& s.ctl[CTL_SM +: 2] == AM_INC)
		|=> s.src == $past(s.src) + 32'h0000_0004)
		else $error("longword unit did not step by four bytes");
	a_cnt_hold: assert property (
		(!pairDone && !swWr) |=> s.cnt == $past(s.cnt))
		else $error("count moved without a completed pair");
	a_start_clear: assert property (
		$rose(s.busOwn) |-> !$past(s.ctl[CTL_TE]) && $past(s.cnt) != '0)
		else $error("channel started with flag set or count zero");
	a_flag_clear: assert property (
		(swWr && avsReq.address == OFS_CTL && avsReq.byteenable[0]
			&& !avsReq.writedata[CTL_TE] && !pairDone)
		|=> !s.ctl[CTL_TE])
		else $error("end flag not cleared by zero write");

	// every request is answered
	a_bus_answer: assert property (
		((avsReq.read || avsReq.write) && s.avsWait) |=> !s.avsWait)
		else $error("register access not answered");

	// main scenarios reached
	c_run_done: cover property ($rose(s.ctl[CTL_TE]));
	c_ext_write: cover property ($fell(s.ebus.weN));
	c_int_read: cover property (s.st == ST_RD && !s.onExt && intAck);
	c_burst: cover property (pairDone ##1 s.st == ST_RDGO);
	c_irq_raise: cover property ($rose(s.irq));
endmodule : dmac_channel

// ---- verilog/dmac_pkg.sv ----
// shared constants, enums and carriers of the dual address dma channel
package dmac_pkg;
	localparam int AW     = 10;
	localparam int CNT_W  = 24;
	localparam int CLK_MHZ = 250;
	// register byte offsets
	localparam logic [AW-1:0] OFS_SRC = 10'h000;
	localparam logic [AW-1:0] OFS_DST = 10'h004;
	localparam logic [AW-1:0] OFS_CNT = 10'h008;
	localparam logic [AW-1:0] OFS_CTL = 10'h00c;
	localparam logic [AW-1:0] OFS_OPR = 10'h200;
	// channel0_control field positions
	localparam int CTL_DE = 0;
	localparam int CTL_TE = 1;
	localparam int CTL_IE = 2;
	localparam int CTL_TS = 3;
	localparam int CTL_TB = 5;
	localparam int CTL_RS = 8;
	localparam int CTL_SM = 12;
	localparam int CTL_DM = 14;
	localparam int OPR_DME = 0;
	localparam logic [15:0] CTL_RST = 16'h0000;
	// encodings
	localparam logic [3:0] RS_AUTO = 4'h4;
	localparam logic [1:0] TS_BYTE = 2'h0;
	localparam logic [1:0] TS_WORD = 2'h1;
	localparam logic [1:0] TS_LONG = 2'h2;
	localparam logic [1:0] AM_INC  = 2'h1;
	localparam logic [1:0] AM_DEC  = 2'h2;
	// internal memory window
	localparam logic [31:0] INT_MASK = 32'hfff0_0000;
	localparam logic [31:0] INT_BASE = 32'hfff0_0000;
	// external strobe width
	localparam int EXT_ACC_NS = 12;
	localparam int EXT_CYC_DEF = (EXT_ACC_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RDGO = 3'b001,
		ST_RD   = 3'b010,
		ST_WRGO = 3'b011,
		ST_WR   = 3'b100
	} dmac_st_t;

	typedef struct packed {
		logic          read;
		logic          write;
		logic [AW-1:0] address;
		logic [31:0]   writedata;
		logic [3:0]    byteenable;
	} dmac_avs_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} dmac_ibus_t;

	typedef struct packed {
		logic        chipSelectN;
		logic        rdN;
		logic        weN;
		logic [31:0] addr;
		logic [31:0] dout;
		logic        doe;
	} dmac_ebus_t;

	typedef struct packed {
		dmac_st_t         st;
		logic [31:0]      src;
		logic [31:0]      dst;
		logic [CNT_W-1:0] cnt;
		logic [15:0]      ctl;
		logic             global_channel_enable;
		logic [31:0]      hold;
		logic [3:0]       tmr;
		logic             onExt;
		logic             busOwn;
		logic             irq;
		logic             avsWait;
		logic [31:0]      rdata;
		dmac_ibus_t       ibus;
		dmac_ebus_t       ebus;
		logic [31:0]      sync1;
		logic [31:0]      sync2;
	} dmac_regs_t;
endpackage : dmac_pkg
